// *** src/dio_edge_level_wait_port.sv ***
// Digital line port with output data/enable per line, eight-line groups and an
// edge/level wait unit with timeout, reached over AHB-Lite.
// Assumes pin inputs are synchronous to mclk and the bench resolves pads.
//
// Overview of operation
// [R1] Any-edge wait stalls until the line changes either way or times out.
// [R2] Falling-edge wait stalls until high-to-low or timeout.
// [R3] Rising-edge wait stalls until low-to-high or timeout.
// [R4] High-level wait releases once line samples high, else waits for timeout.
// [R5] Low-level wait releases once line samples low, else waits for timeout.
// [R6] Timeout is a signed count of module clock cycles.
// [R7] Zero timeout ends the wait at once as timed out.
// [R8] Negative timeout never expires; only the condition ends the wait.
// [R9] Positive timeout counts that many cycles then reports timed out.
// [R10] Lines form eight-line groups, accessible as group or single line.
// [R11] Outputs driven as groups or as lines, never mixed; mixing is rejected.
// [R12] Each line, neighbour and trigger has its own output data and enable.
// [R13] Chassis reference clock is input only, never driven.
// [R14] Module clock may phase-lock to reference; frequency is unchanged.
// [R15] In slot two each left neighbour line acts as star trigger line.
// [R16] In slot two the star trigger line is neither read nor driven.
// [R17] Edges compare current and previous samples; levels use current sample.
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module dio_edge_level_wait_port (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // AHB-Lite slave
   input wire dio_wait_pkg::ahb_req_t ahb_req,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Pins in
   input wire dio_wait_pkg::pin_vec_t pin_in,
   input wire logic chassis_ref_clock,
   // Pins out
   output dio_wait_pkg::pin_vec_t pin_out,
   output dio_wait_pkg::pin_vec_t pin_oe,
   // Clock alignment request to the clock generator
   output logic phase_lock_req,
   // Wait unit status toward user logic
   output logic wait_busy,
   output logic irq
);
   typedef struct packed {
      logic [31:0] hrdata;
      logic wr_pend;
      logic [11:0] waddr;
      dio_wait_pkg::pin_vec_t out_ff;
      dio_wait_pkg::pin_vec_t oe_ff;
      dio_wait_pkg::pin_vec_t smp;
      dio_wait_pkg::pin_vec_t prv;
      logic ref_smp;
      logic ref_prv;
      logic slot_two;
      logic lock_req;
      logic [1:0] used_mode; // bit0 line writes seen, bit1 group writes seen
      dio_wait_pkg::wait_state_t st;
      dio_wait_pkg::wait_kind_t kind;
      logic [dio_wait_pkg::SRC_W-1:0] src;
      logic signed [dio_wait_pkg::TMO_W-1:0] tmo_reg;
      logic signed [dio_wait_pkg::TMO_W-1:0] cnt;
      logic match;
      logic timed_out;
      logic mix_err;
      logic star_err;
      logic [dio_wait_pkg::IRQ_W-1:0] irq_stat;
      logic [dio_wait_pkg::IRQ_W-1:0] irq_mask;
      logic irq;
   } state_t;

   state_t cur_ff, nxt_st;

   // Current and previous sample of every wait source
   logic [dio_wait_pkg::NUM_WAIT_SRC-1:0] src_now, src_old;
   assign src_now = {cur_ff.ref_smp, cur_ff.smp.star, cur_ff.smp.trig,
                     cur_ff.smp.right_nbr, cur_ff.smp.line};
   assign src_old = {cur_ff.ref_prv, cur_ff.prv.star, cur_ff.prv.trig,
                     cur_ff.prv.right_nbr, cur_ff.prv.line};

   // Neighbour sources: left lines outside slot two, right lines in it (left are star)
   logic [dio_wait_pkg::NUM_WAIT_SRC-1:0] eff_now, eff_old;
   always_comb begin
      eff_now = src_now;
      eff_old = src_old;
      if (!cur_ff.slot_two) begin // [R15]
         eff_now[dio_wait_pkg::SRC_NBR_BASE +: dio_wait_pkg::NUM_NBR] = cur_ff.smp.left_nbr;
         eff_old[dio_wait_pkg::SRC_NBR_BASE +: dio_wait_pkg::NUM_NBR] = cur_ff.prv.left_nbr;
      end else begin
         eff_now[dio_wait_pkg::SRC_STAR] = 1'b0; // [R16]
         eff_old[dio_wait_pkg::SRC_STAR] = 1'b0; // [R16]
      end
   end

   logic cur_bit, old_bit, hit;
   logic [31:0] rd_val;
   logic addr_ok;
   logic [11:0] a_addr;
   logic [11:0] grp_off;
   logic [2:0] grp_idx;
   logic [31:0] wd;

   always_comb begin
      nxt_st = cur_ff;
      cur_bit = eff_now[cur_ff.src];
      old_bit = eff_old[cur_ff.src];
      hit = 1'b0;
      rd_val = 32'h0000_0000;
      addr_ok = 1'b0;
      a_addr = ahb_req.haddr[11:0];
      grp_off = 12'h000;
      grp_idx = 3'h0;
      wd = ahb_req.hwdata;

      // Input sampling, two registers per pin: current and previous sample
      nxt_st.smp = pin_in; // [R17]
      nxt_st.prv = cur_ff.smp; // [R17]
      nxt_st.ref_smp = chassis_ref_clock; // [R13]
      nxt_st.ref_prv = cur_ff.ref_smp;
      nxt_st.lock_req = cur_ff.slot_two | cur_ff.lock_req; // [R14]

      // Read of interrupt status clears it first, so events set below win
      if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite &&
          a_addr == dio_wait_pkg::REG_IRQ_STAT) begin
         nxt_st.irq_stat = '0;
      end

      // Condition detection for the selected source
      case (cur_ff.kind)
         dio_wait_pkg::WK_ANY: hit = cur_bit ^ old_bit; // [R1]
         dio_wait_pkg::WK_RISE: hit = cur_bit & ~old_bit; // [R3]
         dio_wait_pkg::WK_FALL: hit = ~cur_bit & old_bit; // [R2]
         dio_wait_pkg::WK_HIGH: hit = cur_bit; // [R4]
         dio_wait_pkg::WK_LOW: hit = ~cur_bit; // [R5]
         default: hit = 1'b0;
      endcase

      // Wait sequencer
      case (cur_ff.st)
         dio_wait_pkg::WS_IDLE: begin
         end
         dio_wait_pkg::WS_WAIT: begin
            if (hit) begin
               nxt_st.st = dio_wait_pkg::WS_IDLE;
               nxt_st.match = 1'b1;
               nxt_st.irq_stat[dio_wait_pkg::IRQ_DONE] = 1'b1;
            end else if (cur_ff.cnt == 32'sd1) begin
               nxt_st.st = dio_wait_pkg::WS_IDLE; // [R9]
               nxt_st.timed_out = 1'b1;
               nxt_st.irq_stat[dio_wait_pkg::IRQ_TMO] = 1'b1;
            end else if (cur_ff.cnt > 32'sd1) begin
               nxt_st.cnt = cur_ff.cnt - 32'sd1; // [R9]
            end
            // Negative count never reaches 1: no expiry [R8]
         end
         default: nxt_st.st = dio_wait_pkg::WS_IDLE;
      endcase

      // AHB read data for a new address phase
      if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]) begin
         addr_ok = 1'b1;
         if (a_addr >= dio_wait_pkg::REG_GROUP_BASE) begin
            grp_off = a_addr - dio_wait_pkg::REG_GROUP_BASE;
            grp_idx = grp_off[4:2];
         end
         case (a_addr)
            dio_wait_pkg::REG_LINE_OUT: rd_val = 32'(cur_ff.out_ff.line);
            dio_wait_pkg::REG_LINE_OE: rd_val = 32'(cur_ff.oe_ff.line);
            dio_wait_pkg::REG_LINE_IN: rd_val = 32'(cur_ff.smp.line);
            dio_wait_pkg::REG_NBR_TRIG_OUT: rd_val = {15'h0, cur_ff.out_ff.star,
               cur_ff.out_ff.trig, cur_ff.out_ff.left_nbr, cur_ff.out_ff.right_nbr};
            dio_wait_pkg::REG_NBR_TRIG_OE: rd_val = {15'h0, cur_ff.oe_ff.star,
               cur_ff.oe_ff.trig, cur_ff.oe_ff.left_nbr, cur_ff.oe_ff.right_nbr};
            dio_wait_pkg::REG_NBR_TRIG_IN: rd_val = {15'h0,
               cur_ff.smp.star & ~cur_ff.slot_two, // [R16]
               cur_ff.smp.trig, cur_ff.smp.left_nbr, cur_ff.smp.right_nbr};
            dio_wait_pkg::REG_CTRL: rd_val = {28'h0, cur_ff.used_mode, cur_ff.lock_req,
               cur_ff.slot_two};
            dio_wait_pkg::REG_WAIT_CMD: rd_val = {19'h0, cur_ff.src, 5'h0, cur_ff.kind};
            dio_wait_pkg::REG_WAIT_TMO: rd_val = cur_ff.tmo_reg;
            dio_wait_pkg::REG_WAIT_STAT: rd_val = {27'h0, cur_ff.star_err, cur_ff.mix_err,
               cur_ff.timed_out, cur_ff.match, cur_ff.st == dio_wait_pkg::WS_WAIT};
            dio_wait_pkg::REG_IRQ_STAT: rd_val = 32'(cur_ff.irq_stat);
            dio_wait_pkg::REG_IRQ_MASK: rd_val = 32'(cur_ff.irq_mask);
            default: begin
               if (a_addr >= dio_wait_pkg::REG_GROUP_BASE && grp_off < 12'h008) begin
                  rd_val = 32'(cur_ff.out_ff.line[grp_idx[0]*8 +: 8]); // [R10]
               end
            end
         endcase
         nxt_st.hrdata = rd_val;
      end
      nxt_st.wr_pend = addr_ok && ahb_req.hwrite;
      nxt_st.waddr = a_addr;

      // AHB write data phase
      if (cur_ff.wr_pend) begin
         case (cur_ff.waddr)
            dio_wait_pkg::REG_LINE_OUT, dio_wait_pkg::REG_LINE_OE: begin
               if (cur_ff.used_mode[1]) begin
                  nxt_st.mix_err = 1'b1; // [R11]
                  nxt_st.irq_stat[dio_wait_pkg::IRQ_MIX] = 1'b1;
               end else begin
                  nxt_st.used_mode[0] = 1'b1;
                  if (cur_ff.waddr == dio_wait_pkg::REG_LINE_OUT)
                     nxt_st.out_ff.line = wd[dio_wait_pkg::NUM_LINES-1:0]; // [R12]
                  else
                     nxt_st.oe_ff.line = wd[dio_wait_pkg::NUM_LINES-1:0]; // [R12]
               end
            end
            dio_wait_pkg::REG_NBR_TRIG_OUT, dio_wait_pkg::REG_NBR_TRIG_OE: begin
               if (cur_ff.slot_two && wd[16]) begin
                  nxt_st.star_err = 1'b1; // [R16]
                  nxt_st.irq_stat[dio_wait_pkg::IRQ_STAR] = 1'b1;
               end
               if (cur_ff.waddr == dio_wait_pkg::REG_NBR_TRIG_OUT)
                  {nxt_st.out_ff.star, nxt_st.out_ff.trig, nxt_st.out_ff.left_nbr,
                   nxt_st.out_ff.right_nbr} = wd[16:0]; // [R12]
               else
                  {nxt_st.oe_ff.star, nxt_st.oe_ff.trig, nxt_st.oe_ff.left_nbr,
                   nxt_st.oe_ff.right_nbr} = wd[16:0]; // [R12]
            end
            dio_wait_pkg::REG_CTRL: begin
               nxt_st.slot_two = wd[dio_wait_pkg::CTRL_SLOT_TWO];
               if (wd[dio_wait_pkg::CTRL_GROUP_MODE + 2]) nxt_st.used_mode = 2'b00;
            end
            dio_wait_pkg::REG_WAIT_TMO: nxt_st.tmo_reg = wd; // [R6]
            dio_wait_pkg::REG_WAIT_CMD: begin
               if (cur_ff.st == dio_wait_pkg::WS_IDLE) begin
                  nxt_st.kind = dio_wait_pkg::wait_kind_t'(wd[2:0]);
                  nxt_st.src = wd[dio_wait_pkg::CMD_SRC_LSB +: dio_wait_pkg::SRC_W];
                  nxt_st.match = 1'b0;
                  nxt_st.timed_out = 1'b0;
                  if (cur_ff.tmo_reg == 32'sd0) begin
                     nxt_st.timed_out = 1'b1; // [R7]
                     nxt_st.irq_stat[dio_wait_pkg::IRQ_TMO] = 1'b1;
                  end else begin
                     nxt_st.st = dio_wait_pkg::WS_WAIT;
                     nxt_st.cnt = cur_ff.tmo_reg; // [R8] [R9]
                  end
               end
            end
            dio_wait_pkg::REG_WAIT_STAT: begin
               if (wd[dio_wait_pkg::ST_MIX_ERR]) nxt_st.mix_err = 1'b0;
               if (wd[dio_wait_pkg::ST_STAR_ERR]) nxt_st.star_err = 1'b0;
            end
            dio_wait_pkg::REG_IRQ_MASK: nxt_st.irq_mask = wd[dio_wait_pkg::IRQ_W-1:0];
            default: begin
               if (cur_ff.waddr >= dio_wait_pkg::REG_GROUP_BASE &&
                   cur_ff.waddr < dio_wait_pkg::REG_GROUP_BASE + 12'h010) begin
                  if (cur_ff.used_mode[0]) begin
                     nxt_st.mix_err = 1'b1; // [R11]
                     nxt_st.irq_stat[dio_wait_pkg::IRQ_MIX] = 1'b1;
                  end else begin
                     nxt_st.used_mode[1] = 1'b1;
                     // Offsets 0x40/0x44 data, 0x48/0x4c enable of groups 0/1
                     if (cur_ff.waddr[3])
                        nxt_st.oe_ff.line[cur_ff.waddr[2]*8 +: 8] = wd[7:0]; // [R10]
                     else
                        nxt_st.out_ff.line[cur_ff.waddr[2]*8 +: 8] = wd[7:0]; // [R10]
                  end
               end
            end
         endcase
      end

      // Star trigger never driven in slot two
      if (nxt_st.slot_two) nxt_st.oe_ff.star = 1'b0; // [R16]
      // Left neighbours serve as star lines in slot two; same drivers [R15]
      nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
   end

   // State register
   always_ff @(posedge mclk) begin
      if (srst) begin
         cur_ff <= '0;
         cur_ff.st <= dio_wait_pkg::WS_IDLE;
      end else begin
         cur_ff <= nxt_st;
      end
   end

   // Outputs from flip-flops; hreadyout and hresp are constants
   assign hrdata = cur_ff.hrdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign pin_out = cur_ff.out_ff;
   assign pin_oe = cur_ff.oe_ff;
   assign phase_lock_req = cur_ff.lock_req;
   assign wait_busy = cur_ff.st == dio_wait_pkg::WS_WAIT;
   assign irq = cur_ff.irq;
endmodule

// *** src/dio_wait_pkg.sv ***
// Constants, register map and carrier types for the edge/level wait I/O port.
// Assumes a single 40 MHz clock and an AHB-Lite register slave.
package dio_wait_pkg;
   localparam int unsigned NUM_GROUPS = 2;
   localparam int unsigned GROUP_W = 8;
   localparam int unsigned NUM_LINES = NUM_GROUPS * GROUP_W;
   localparam int unsigned NUM_NBR = 4;
   localparam int unsigned NUM_TRIG = 8;
   localparam int unsigned NUM_WAIT_SRC = NUM_LINES + NUM_NBR + NUM_TRIG + 2;
   localparam int unsigned SRC_W = 5;
   localparam int unsigned TMO_W = 32;
   // Register byte addresses
   localparam logic [11:0] REG_LINE_OUT = 12'h000;
   localparam logic [11:0] REG_LINE_OE = 12'h004;
   localparam logic [11:0] REG_LINE_IN = 12'h008;
   localparam logic [11:0] REG_NBR_TRIG_OUT = 12'h00c;
   localparam logic [11:0] REG_NBR_TRIG_OE = 12'h010;
   localparam logic [11:0] REG_NBR_TRIG_IN = 12'h014;
   localparam logic [11:0] REG_CTRL = 12'h018;
   localparam logic [11:0] REG_WAIT_CMD = 12'h01c;
   localparam logic [11:0] REG_WAIT_TMO = 12'h020;
   localparam logic [11:0] REG_WAIT_STAT = 12'h024;
   localparam logic [11:0] REG_IRQ_STAT = 12'h028;
   localparam logic [11:0] REG_IRQ_MASK = 12'h02c;
   localparam logic [11:0] REG_GROUP_BASE = 12'h040;
   // Control register fields
   localparam int unsigned CTRL_SLOT_TWO = 0;
   localparam int unsigned CTRL_GROUP_MODE = 1;
   // Wait command fields: kind in [2:0], source in [12:8]
   localparam int unsigned CMD_SRC_LSB = 8;
   // Status bits
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_MATCH = 1;
   localparam int unsigned ST_TIMEOUT = 2;
   localparam int unsigned ST_MIX_ERR = 3;
   localparam int unsigned ST_STAR_ERR = 4;
   // Interrupt events
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_TMO = 1;
   localparam int unsigned IRQ_MIX = 2;
   localparam int unsigned IRQ_STAR = 3;
   localparam int unsigned IRQ_W = 4;
   // Wait sources beyond the digital lines
   localparam logic [SRC_W-1:0] SRC_NBR_BASE = 5'd16;
   localparam logic [SRC_W-1:0] SRC_TRIG_BASE = 5'd20;
   localparam logic [SRC_W-1:0] SRC_STAR = 5'd28;
   localparam logic [SRC_W-1:0] SRC_REF = 5'd29;

   typedef enum logic [2:0] {
      WK_ANY = 3'h0,
      WK_RISE = 3'h1,
      WK_FALL = 3'h2,
      WK_HIGH = 3'h3,
      WK_LOW = 3'h4
   } wait_kind_t;

   typedef enum logic [1:0] {
      WS_IDLE = 2'b01,
      WS_WAIT = 2'b10
   } wait_state_t;

   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
      logic hready;
      logic [31:0] hwdata;
   } ahb_req_t;

   typedef struct packed {
      logic [NUM_LINES-1:0] line;
      logic [NUM_NBR-1:0] right_nbr;
      logic [NUM_NBR-1:0] left_nbr;
      logic [NUM_TRIG-1:0] trig;
      logic star;
   } pin_vec_t;
endpackage

// *** bench/dio_pin_model.sv ***
// Far-side model: pads resolved against external drivers, chassis reference.
// Assumes the bench supplies the external line levels on ext every cycle.
`timescale 1ns/1ps
module dio_pin_model (
   // Clock
   input wire logic mclk,
   // From the port
   input wire dio_wait_pkg::pin_vec_t pin_out,
   input wire dio_wait_pkg::pin_vec_t pin_oe,
   // External drivers
   input wire dio_wait_pkg::pin_vec_t ext,
   // To the port
   output dio_wait_pkg::pin_vec_t pin_in,
   output logic chassis_ref_clock
);
   logic ref_ph = 1'b0;
   // Driven lines loop back, released lines follow the outside world
   assign pin_in = dio_wait_pkg::pin_vec_t'((pin_out & pin_oe) | (ext & ~pin_oe));
   // Reference at a quarter of 40 MHz, only ever driven from outside
   always @(posedge mclk) begin
      ref_ph <= ~ref_ph;
      if (ref_ph) begin
         chassis_ref_clock <= ~chassis_ref_clock;
      end
   end
   initial chassis_ref_clock = 1'b0;
endmodule

// *** bench/dio_wait_asserts.sv ***
// Port-level checker for the edge/level wait port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module dio_wait_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Bus
   input wire dio_wait_pkg::ahb_req_t ahb_req,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Pins
   input wire dio_wait_pkg::pin_vec_t pin_in,
   input wire logic chassis_ref_clock,
   input wire dio_wait_pkg::pin_vec_t pin_out,
   input wire dio_wait_pkg::pin_vec_t pin_oe,
   // Status
   input wire logic phase_lock_req,
   input wire logic wait_busy,
   input wire logic irq
);
   logic dph_wr_ff;
   logic dph_rd_ff;
   logic [11:0] dph_a_ff;
   logic [31:0] tmo_ff;
   logic slot_ff;
   logic [31:0] cnt_ff;
   wire logic take = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
   wire logic wcmd = dph_wr_ff && (dph_a_ff == dio_wait_pkg::REG_WAIT_CMD);
   wire logic irq_acc = (dph_rd_ff && (dph_a_ff == dio_wait_pkg::REG_IRQ_STAT)) ||
      (dph_wr_ff && (dph_a_ff == dio_wait_pkg::REG_IRQ_MASK));
   // Shadow of data phases, timeout, slot bit and busy length
   always_ff @(posedge mclk) begin
      if (srst) begin
         dph_wr_ff <= 1'b0;
         dph_rd_ff <= 1'b0;
         dph_a_ff <= 12'h000;
         tmo_ff <= 32'h0;
         slot_ff <= 1'b0;
         cnt_ff <= 32'h0;
      end else begin
         dph_wr_ff <= take & ahb_req.hwrite;
         dph_rd_ff <= take & ~ahb_req.hwrite;
         dph_a_ff <= ahb_req.haddr[11:0];
         if (dph_wr_ff && (dph_a_ff == dio_wait_pkg::REG_WAIT_TMO)) tmo_ff <= ahb_req.hwdata;
         if (dph_wr_ff && (dph_a_ff == dio_wait_pkg::REG_CTRL)) slot_ff <= ahb_req.hwdata[0];
         cnt_ff <= wait_busy ? cnt_ff + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   property p_bus_ok; hreadyout && !hresp; endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");
   property p_lock_sticky; phase_lock_req |=> phase_lock_req; endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock request dropped");
   property p_busy_cause; $rose(wait_busy) |-> $past(wcmd); endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
   property p_zero_tmo; wcmd && (tmo_ff == 32'h0) && !wait_busy |=> !wait_busy [*2]; endproperty
   a_zero_tmo: assert property (p_zero_tmo) else $error("zero timeout went busy");
   property p_pos_tmo; wait_busy && !tmo_ff[31] && (tmo_ff != 32'h0) |-> cnt_ff <= tmo_ff;
   endproperty
   a_pos_tmo: assert property (p_pos_tmo) else $error("wait outlived timeout");
   property p_out_cause; !$stable({pin_out.line, pin_oe.line}) |-> $past(dph_wr_ff); endproperty
   a_out_cause: assert property (p_out_cause) else $error("line output moved unasked");
   property p_star_off; slot_ff && $past(slot_ff) |-> !pin_oe.star; endproperty
   a_star_off: assert property (p_star_off) else $error("star driven in slot two");
   property p_irq_fall; $fell(irq) |-> irq_acc || $past(irq_acc); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without clear");
   // Main scenarios
   c_busy: cover property ($rose(wait_busy));
   c_irq: cover property ($rose(irq));
   c_lock: cover property ($rose(phase_lock_req));
endmodule
bind dio_edge_level_wait_port dio_wait_asserts u_chk (.mclk(mclk), .srst(srst),
   .ahb_req(ahb_req), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .pin_in(pin_in), .chassis_ref_clock(chassis_ref_clock), .pin_out(pin_out),
   .pin_oe(pin_oe), .phase_lock_req(phase_lock_req), .wait_busy(wait_busy), .irq(irq));

// *** bench/dio_edge_level_wait_port_bench.sv ***
// Self-checking bench for the edge/level wait port over AHB-Lite.
// Assumes the pin model resolves pads and makes the reference clock.
`timescale 1ns/1ps
module dio_edge_level_wait_port_bench;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   dio_wait_pkg::ahb_req_t req = '0;
   dio_wait_pkg::pin_vec_t ext = '0;
   dio_wait_pkg::pin_vec_t pin_in;
   dio_wait_pkg::pin_vec_t pin_out;
   dio_wait_pkg::pin_vec_t pin_oe;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic ref_clk;
   logic phase_lock_req;
   logic wait_busy;
   logic irq;
   int failures = 0;
   int n_compared = 0;
   // 40 MHz clock, single slave drives hready
   always #12.5 mclk = ~mclk;
   dio_wait_pkg::ahb_req_t bus_req;
   always_comb begin
      bus_req = req;
      bus_req.hready = hreadyout;
   end
   dio_edge_level_wait_port dut (.mclk(mclk), .srst(srst), .ahb_req(bus_req), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .chassis_ref_clock(ref_clk),
      .pin_out(pin_out), .pin_oe(pin_oe), .phase_lock_req(phase_lock_req),
      .wait_busy(wait_busy), .irq(irq));
   dio_pin_model pads (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext(ext),
      .pin_in(pin_in), .chassis_ref_clock(ref_clk));
   task automatic report_and_stop();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One single word transfer, address phase then data phase
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge mclk);
      req.haddr <= {20'h00000, a};
      req.htrans <= 2'b10;
      req.hwrite <= w;
      req.hsize <= 3'h2;
      req.hsel <= 1'b1;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      req.htrans <= 2'b00;
      req.hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   // Counts busy cycles, bounded
   task automatic wait_idle(output int n);
      settle(1);
      n = 0;
      while (wait_busy === 1'b1 && n < 100) begin
         n++;
         @(negedge mclk);
      end
   endtask
   task automatic t_reset();
      logic [31:0] r;
      rd(dio_wait_pkg::REG_LINE_OE, r);
      chk("line_oe", r, 32'h0);
      rd(dio_wait_pkg::REG_WAIT_STAT, r);
      chk("wait_stat", r, 32'h0);
      rd(12'h030, r);
      chk("unmapped", r, 32'h0);
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic t_waits();
      logic [4:0] init = 5'b10010;
      logic [4:0] mid = 5'b10100;
      logic [4:0] fin = 5'b01011;
      logic [31:0] r;
      int n;
      for (int k = 0; k < 5; k++) begin
         @(posedge mclk) ext.line[0] <= init[k];
         wr(dio_wait_pkg::REG_WAIT_TMO, 32'hffffffff);
         wr(dio_wait_pkg::REG_WAIT_CMD, 32'(k));
         settle(3);
         chk("busy_start", {31'h0, wait_busy}, 32'h1);
         @(posedge mclk) ext.line[0] <= mid[k];
         settle(4);
         chk("busy_mid", {31'h0, wait_busy}, 32'h1);
         @(posedge mclk) ext.line[0] <= fin[k];
         wait_idle(n);
         chk("release", 32'(n < 10), 32'h1);
         rd(dio_wait_pkg::REG_WAIT_STAT, r);
         chk("stat_match", {29'h0, r[2:0]}, 32'h2);
      end
      wr(dio_wait_pkg::REG_WAIT_CMD, 32'h1 | (32'(dio_wait_pkg::SRC_REF) << 8));
      wait_idle(n);
      rd(dio_wait_pkg::REG_WAIT_STAT, r);
      chk("ref_rise", {29'h0, r[2:0]}, 32'h2);
   endtask
   task automatic t_timeouts();
      logic [31:0] r;
      int n;
      wr(dio_wait_pkg::REG_IRQ_MASK, 32'h0);
      wr(dio_wait_pkg::REG_WAIT_TMO, 32'h0);
      wr(dio_wait_pkg::REG_WAIT_CMD, 32'h3);
      settle(1);
      chk("zero_busy", {31'h0, wait_busy}, 32'h0);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      rd(dio_wait_pkg::REG_WAIT_STAT, r);
      chk("zero_stat", {29'h0, r[2:0]}, 32'h4);
      rd(dio_wait_pkg::REG_IRQ_STAT, r);
      wr(dio_wait_pkg::REG_IRQ_MASK, 32'h1 << dio_wait_pkg::IRQ_TMO);
      wr(dio_wait_pkg::REG_WAIT_TMO, 32'h6);
      wr(dio_wait_pkg::REG_WAIT_CMD, 32'h3);
      wait_idle(n);
      chk("tmo_len", 32'(n >= 5 && n <= 6), 32'h1);
      settle(1);
      chk("irq_up", {31'h0, irq}, 32'h1);
      rd(dio_wait_pkg::REG_IRQ_STAT, r);
      chk("irq_tmo", {31'h0, r[dio_wait_pkg::IRQ_TMO]}, 32'h1);
      settle(1);
      chk("irq_clr", {31'h0, irq}, 32'h0);
      rd(dio_wait_pkg::REG_WAIT_STAT, r);
      chk("tmo_stat", {29'h0, r[2:0]}, 32'h4);
   endtask
   task automatic t_mix();
      logic [31:0] r;
      wr(dio_wait_pkg::REG_CTRL, 32'h8);
      wr(dio_wait_pkg::REG_LINE_OUT, 32'ha5c3);
      wr(dio_wait_pkg::REG_LINE_OE, 32'hffff);
      rd(dio_wait_pkg::REG_LINE_IN, r);
      chk("line_in", r, 32'ha5c3);
      wr(dio_wait_pkg::REG_GROUP_BASE, 32'h11);
      settle(1);
      chk("mix_kept", {16'h0, pin_out.line}, 32'ha5c3);
      rd(dio_wait_pkg::REG_WAIT_STAT, r);
      chk("mix_err", {31'h0, r[dio_wait_pkg::ST_MIX_ERR]}, 32'h1);
      wr(dio_wait_pkg::REG_CTRL, 32'h8);
      wr(dio_wait_pkg::REG_WAIT_STAT, 32'h8);
      wr(dio_wait_pkg::REG_GROUP_BASE + 12'h004, 32'h5a);
      wr(dio_wait_pkg::REG_GROUP_BASE + 12'h00c, 32'hff);
      settle(1);
      chk("group1", {24'h0, pin_out.line[15:8]}, 32'h5a);
      rd(dio_wait_pkg::REG_WAIT_STAT, r);
      chk("no_mix", {31'h0, r[dio_wait_pkg::ST_MIX_ERR]}, 32'h0);
   endtask
   task automatic t_slot();
      logic [31:0] r;
      wr(dio_wait_pkg::REG_NBR_TRIG_OUT, 32'h0001a56c);
      wr(dio_wait_pkg::REG_NBR_TRIG_OE, 32'h0001ffff);
      settle(1);
      chk("star_oe", {31'h0, pin_oe.star}, 32'h1);
      chk("trig_out", {24'h0, pin_out.trig}, 32'ha5);
      wr(dio_wait_pkg::REG_CTRL, 32'h1);
      settle(2);
      chk("lock", {31'h0, phase_lock_req}, 32'h1);
      chk("star_off", {31'h0, pin_oe.star}, 32'h0);
      chk("left_oe", {28'h0, pin_oe.left_nbr}, 32'hf);
      @(posedge mclk) ext.star <= 1'b1;
      wr(dio_wait_pkg::REG_NBR_TRIG_OE, 32'h0001ffff);
      rd(dio_wait_pkg::REG_WAIT_STAT, r);
      chk("star_err", {31'h0, r[dio_wait_pkg::ST_STAR_ERR]}, 32'h1);
      rd(dio_wait_pkg::REG_NBR_TRIG_IN, r);
      chk("star_in", {31'h0, r[16]}, 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      t_reset();
      t_waits();
      t_timeouts();
      t_mix();
      t_slot();
      report_and_stop();
   end
   // Hang guard, far beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      report_and_stop();
   end
endmodule
